// file: osc_trim_spread_ctrl_map.svh
`ifndef OSC_TRIM_SPREAD_CTRL_MAP_SVH
`define OSC_TRIM_SPREAD_CTRL_MAP_SVH

`define ADDR_FAST_OSC_COARSE_TRIM 16'ha001
`define ADDR_FAST_OSC_FINE_TRIM   16'ha002
`define ADDR_CRYSTAL_OSC_CONFIG   16'ha007
`define ADDR_OSC_STATUS           16'ha0f0
`define ADDR_OSC_CONTROL_CODE     16'ha0f1

`define RST_FAST_OSC_COARSE_TRIM  8'h01
`define RST_FAST_OSC_FINE_TRIM    8'h8e
`define RST_CRYSTAL_OSC_CONFIG    8'h00

`define POS_SWEEP_RATE_LSB        4
`define POS_SWEEP_AMP_LSB         2
`define POS_COARSE_TRIM_LSB       0
`define POS_SLOW32K_EN            7
`define POS_XTAL_EXT_CLK          3

`define CFG_WRITABLE_MASK         8'h8f
`define AMP_BASE                  7'h04

`define OSC_SETTLE_NS             100
`define SYS_CLK_PERIOD_NS         10
`define OSC_SETTLE_CYCLES         (`OSC_SETTLE_NS / `SYS_CLK_PERIOD_NS)

`endif

// file: osc_trim_spread_ctrl_pkg.sv
package osc_trim_spread_ctrl_pkg;

  typedef enum logic [2:0] {
    XTAL_OFF,
    XTAL_LOW,
    XTAL_MED,
    XTAL_HIGH,
    XTAL_CUSTOM,
    XTAL_EXT
  } xtal_mode_t;

  typedef struct packed {
    logic              active;
    logic [3:0]        interval;
    logic signed [6:0] offset;
    logic              dir_up;
    logic [7:0]        code;
  } sweep_state_t;

  typedef struct packed {
    logic [7:0] coarse;
    logic [7:0] fine;
    logic [7:0] cfg;
    logic [7:0] rdata;
    logic       osc_en;
    logic [3:0] settle;
    logic       osc_ready;
  } trim_state_t;

endpackage

// file: osc_sweep_gen.sv
`timescale 1ns/1ps
`include "osc_trim_spread_ctrl_map.svh"

module osc_sweep_gen
  import osc_trim_spread_ctrl_pkg::*;
#(
  parameter int RATE_W = 4
) (
  input  wire logic              sys_clk_in,
  input  wire logic              resetn_in,
  input  wire logic [RATE_W-1:0] sweep_rate_code_in,
  input  wire logic [1:0]        sweep_amplitude_sel_in,
  input  wire logic [7:0]        fine_trim_in,
  output logic [7:0]             osc_control_code_out,
  output logic                   sweep_active_out
);

  generate
    if (RATE_W != 4) begin : g_bad_rate
      $error("sweep rate field must be four bits wide");
    end
  endgenerate

  sweep_state_t st;
  sweep_state_t next_st;
  logic signed [6:0] amp;
  logic signed [6:0] stepped;
  logic signed [9:0] sum;

  always_comb begin
    amp = `AMP_BASE << sweep_amplitude_sel_in; // RL2
    stepped = st.dir_up ? st.offset + 7'sd1 : st.offset - 7'sd1;
    sum = $signed({2'b00, fine_trim_in}) + 10'(st.offset); // RL5
    next_st = st;
    if (sweep_rate_code_in == '0) begin
      next_st.active = 1'b0; // RL1
      next_st.interval = '0;
      next_st.offset = '0;
      next_st.dir_up = 1'b1;
      next_st.code = fine_trim_in; // RL1
    end else begin
      if (!st.active) begin
        next_st.active = 1'b1; // RL19
        next_st.interval = '0;
        next_st.offset = '0;
        next_st.dir_up = 1'b1;
      end else if (st.interval == sweep_rate_code_in - 4'd1) begin
        next_st.interval = '0; // RL3
        next_st.offset = stepped; // RL19
        if (stepped >= amp) begin
          next_st.dir_up = 1'b0; // RL4
        end else if (stepped <= -amp) begin
          next_st.dir_up = 1'b1; // RL4
        end
      end else begin
        next_st.interval = st.interval + 4'd1;
      end
      // clamp rather than wrap so a badly placed trim flattens, never jumps
      if (sum < 10'sd0) begin
        next_st.code = 8'h00; // RL5
      end else if (sum > 10'sd255) begin
        next_st.code = 8'hff; // RL5
      end else begin
        next_st.code = sum[7:0]; // RL5
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '{active: 1'b0, interval: 4'h0, offset: 7'h00, dir_up: 1'b1,
              code: `RST_FAST_OSC_FINE_TRIM};
    end else begin
      st <= next_st;
    end
  end

  assign osc_control_code_out = st.code;
  assign sweep_active_out = st.active;

endmodule

// file: osc_trim_spread_ctrl.sv
`timescale 1ns/1ps
`include "osc_trim_spread_ctrl_map.svh"

// Operation
// RL1: sweep rate zero disables spreading; oscillator gets fine trim unchanged.
// RL2: amplitude select 11/10/01/00 gives deviation 32/16/8/4.
// RL3: while spreading, control code updates every N clock cycles, N = rate.
// RL4: one full sweep spans four amplitude legs of N cycles per step.
// RL5: control code is fine trim plus offset, clamped to 0..255.
// RL6: software keeps fine trim within amplitude..256-amplitude to avoid clipping.
// RL7: every reset returns coarse trim to 01 and fine trim to 8e.
// RL8: software reloads calibrated trims from the info block after reset.
// RL9: fast oscillator runs always except in the halt state.
// RL10: oscillator on/off is glitch free; ready flagged ten cycles later. The code raises ready eleven cycles after the enable flop rises.
// RL11: software calibrates with coarse 01, probes 00, ff, 7f, then bisects.
// RL12: crystal config register cleared only by power-on reset.
// RL13: slow 32k enable bit powers that oscillator and connects its pads.
// RL14: crystal code 0000 powers down; 0001/0011/0111 select low/medium/high drive.
// RL15: crystal bit 3 set takes external clock on the output pin.
// RL16: software sets bit 3 only, freeing the crystal input pin.
// RL17: software sets both crystal pins to high impedance before use.
// RL18: software waits tens of milliseconds for crystal start-up.
// RL19: offset steps by one in a triangle, restarting at zero on enable.
// RL20: writes to the three trim/config registers need the unlock permit.

module osc_trim_spread_ctrl
  import osc_trim_spread_ctrl_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int RATE_W = 4
) (
  input  wire logic              sys_clk_in,
  input  wire logic              resetn_in,
  input  wire logic              soft_reset_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [7:0]        wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  input  wire logic              write_unlock_in,
  input  wire logic              halt_req_in,
  output logic [7:0]             rdata_out,
  output logic [7:0]             osc_control_code_out,
  output logic [1:0]             coarse_trim_out,
  output logic                   sweep_active_out,
  output logic                   internal_fast_osc_en_out,
  output logic                   internal_fast_osc_ready_out,
  output logic                   crystal_osc_powerdown_out,
  output logic [2:0]             crystal_drive_ctrl_out,
  output logic                   crystal_ext_clk_sel_out,
  output logic                   slow32k_osc_enable_out,
  output logic                   analog_pad_connect_out
);

  generate
    if (ADDR_W != 16) begin : g_bad_addr
      $error("register address must be sixteen bits wide");
    end
    if (RATE_W != 4) begin : g_bad_rate
      $error("sweep rate field must be four bits wide");
    end
  endgenerate

  localparam logic [3:0] SETTLE_CYCLES = 4'(`OSC_SETTLE_CYCLES);

  function automatic xtal_mode_t xtal_mode(input logic [7:0] cfg);
    xtal_mode_t m;
    m = XTAL_CUSTOM;
    if (cfg[`POS_XTAL_EXT_CLK]) begin
      m = XTAL_EXT; // RL15
    end else begin
      unique case (cfg[2:0])
        3'h0: m = XTAL_OFF; // RL14
        3'h1: m = XTAL_LOW; // RL14
        3'h3: m = XTAL_MED; // RL14
        3'h7: m = XTAL_HIGH; // RL14
        default: m = XTAL_CUSTOM;
      endcase
    end
    return m;
  endfunction

  trim_state_t st;
  trim_state_t next_st;
  xtal_mode_t  mode;
  logic [7:0]  ctrl_code;
  logic        sweep_act;
  logic        wr_ok;

  assign mode = xtal_mode(st.cfg);
  // protection permit is sampled with the strobe; a locked write is dropped silently
  assign wr_ok = wr_in && write_unlock_in; // RL20

  always_comb begin
    next_st = st;
    if (wr_ok) begin
      unique case (addr_in)
        `ADDR_FAST_OSC_COARSE_TRIM: next_st.coarse = wdata_in;
        `ADDR_FAST_OSC_FINE_TRIM: next_st.fine = wdata_in;
        `ADDR_CRYSTAL_OSC_CONFIG: next_st.cfg = wdata_in & `CFG_WRITABLE_MASK;
        default: ;
      endcase
    end
    if (soft_reset_in) begin
      next_st.coarse = `RST_FAST_OSC_COARSE_TRIM; // RL7
      next_st.fine = `RST_FAST_OSC_FINE_TRIM; // RL7
      // cfg deliberately untouched so pad setup survives warm resets
      next_st.cfg = st.cfg; // RL12
    end
    next_st.rdata = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        `ADDR_FAST_OSC_COARSE_TRIM: next_st.rdata = st.coarse;
        `ADDR_CRYSTAL_OSC_CONFIG: next_st.rdata = st.cfg;
        `ADDR_OSC_STATUS: next_st.rdata = {3'h0, mode, sweep_act, st.osc_ready};
        `ADDR_OSC_CONTROL_CODE: next_st.rdata = ctrl_code;
        default: next_st.rdata = 8'h00;
      endcase
    end
    next_st.osc_en = !halt_req_in; // RL9
    // enable is a flop so the oscillator gate sees one clean edge
    if (!st.osc_en) begin
      next_st.settle = '0; // RL10
      next_st.osc_ready = 1'b0;
    end else if (st.settle != SETTLE_CYCLES) begin
      next_st.settle = st.settle + 4'd1; // RL10
      next_st.osc_ready = 1'b0;
    end else begin
      next_st.osc_ready = 1'b1; // RL10
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '{coarse: `RST_FAST_OSC_COARSE_TRIM, fine: `RST_FAST_OSC_FINE_TRIM,
              cfg: `RST_CRYSTAL_OSC_CONFIG, rdata: 8'h00, osc_en: 1'b1,
              settle: 4'h0, osc_ready: 1'b0}; // RL7 RL12
    end else begin
      st <= next_st;
    end
  end

  osc_sweep_gen #(
    .RATE_W (RATE_W)
  ) u_sweep (
    .sys_clk_in             (sys_clk_in),
    .resetn_in              (resetn_in),
    .sweep_rate_code_in     (st.coarse[`POS_SWEEP_RATE_LSB +: 4]),
    .sweep_amplitude_sel_in (st.coarse[`POS_SWEEP_AMP_LSB +: 2]),
    .fine_trim_in           (st.fine),
    .osc_control_code_out   (ctrl_code),
    .sweep_active_out       (sweep_act)
  );

  assign rdata_out = st.rdata;
  assign osc_control_code_out = ctrl_code;
  assign coarse_trim_out = st.coarse[`POS_COARSE_TRIM_LSB +: 2];
  assign sweep_active_out = sweep_act;
  assign internal_fast_osc_en_out = st.osc_en; // RL9
  assign internal_fast_osc_ready_out = st.osc_ready;
  assign crystal_osc_powerdown_out = (mode == XTAL_OFF); // RL14
  assign crystal_drive_ctrl_out = st.cfg[`POS_XTAL_EXT_CLK] ? 3'h0 : st.cfg[2:0]; // RL14 RL15
  assign crystal_ext_clk_sel_out = st.cfg[`POS_XTAL_EXT_CLK]; // RL15
  assign slow32k_osc_enable_out = st.cfg[`POS_SLOW32K_EN]; // RL13
  assign analog_pad_connect_out = st.cfg[`POS_SLOW32K_EN]; // RL13

endmodule

// file: osc_trim_spread_ctrl_asserts.sv
`timescale 1ns/1ps
`include "osc_trim_spread_ctrl_map.svh"
module osc_trim_spread_ctrl_asserts
  import osc_trim_spread_ctrl_pkg::*;
#(parameter int ADDR_W = 16, parameter int RATE_W = 4) (
  input wire logic              sys_clk_in,
  input wire logic              resetn_in,
  input wire logic              soft_reset_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0]        wdata_in,
  input wire logic              wr_in,
  input wire logic              rd_in,
  input wire logic              write_unlock_in,
  input wire logic              halt_req_in,
  input wire logic [7:0]        rdata_out,
  input wire logic [7:0]        osc_control_code_out,
  input wire logic              sweep_active_out,
  input wire logic              internal_fast_osc_en_out,
  input wire logic              internal_fast_osc_ready_out,
  input wire logic              crystal_osc_powerdown_out,
  input wire logic [2:0]        crystal_drive_ctrl_out,
  input wire logic              crystal_ext_clk_sel_out,
  input wire logic              slow32k_osc_enable_out,
  input wire logic              analog_pad_connect_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_cw;
    wr_in && write_unlock_in && addr_in == `ADDR_FAST_OSC_COARSE_TRIM;
  endsequence
  sequence s_go;
    s_cw ##0 (!soft_reset_in && wdata_in[7:4] != 4'h0);
  endsequence
  property p_on; s_go |-> ##2 sweep_active_out; endproperty
  property p_off; s_cw ##0 (wdata_in[7:4] == 4'h0) |-> ##2 !sweep_active_out; endproperty
  property p_srst; soft_reset_in |-> ##2 !sweep_active_out; endproperty
  property p_rd; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
  property p_en; internal_fast_osc_en_out == !$past(halt_req_in); endproperty
  property p_rdy; $rose(internal_fast_osc_ready_out) |-> $past(internal_fast_osc_en_out, 9);
  endproperty
  property p_ext; crystal_ext_clk_sel_out |-> crystal_drive_ctrl_out == 3'h0; endproperty
  property p_pd; crystal_osc_powerdown_out |-> !crystal_ext_clk_sel_out; endproperty
  property p_pad; slow32k_osc_enable_out == analog_pad_connect_out; endproperty
  // clamping can hold the code, so a step of zero is legal
  property p_step;
    sweep_active_out && $past(sweep_active_out) && !$past(wr_in) && !$past(wr_in, 2)
      && !$past(soft_reset_in) |-> ($past(osc_control_code_out) - osc_control_code_out)
      inside {8'h00, 8'h01, 8'hff};
  endproperty
  a_on: assert property (p_on) else $error("sweep not started");
  a_off: assert property (p_off) else $error("sweep not stopped");
  a_srst: assert property (p_srst) else $error("sweep kept after soft reset");
  a_rd: assert property (p_rd) else $error("read data not idle");
  a_en: assert property (p_en) else $error("oscillator enable wrong");
  a_rdy: assert property (p_rdy) else $error("ready too early");
  a_ext: assert property (p_ext) else $error("drive with external clock");
  a_pd: assert property (p_pd) else $error("powerdown with external clock");
  a_pad: assert property (p_pad) else $error("pad connect differs");
  a_step: assert property (p_step) else $error("sweep step not one");
endmodule
bind osc_trim_spread_ctrl osc_trim_spread_ctrl_asserts #(.ADDR_W(ADDR_W), .RATE_W(RATE_W))
  chk_u (.*);

// file: test_osc_trim_spread_ctrl.sv
`timescale 1ns/1ps
`include "osc_trim_spread_ctrl_map.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_osc_trim_spread_ctrl;
  logic        sys_clk_in, resetn_in, soft_reset_in, wr_in, rd_in, write_unlock_in;
  logic        halt_req_in, sweep_active_out, internal_fast_osc_en_out;
  logic        internal_fast_osc_ready_out, crystal_osc_powerdown_out;
  logic        crystal_ext_clk_sel_out, slow32k_osc_enable_out, analog_pad_connect_out;
  logic [15:0] addr_in;
  logic [7:0]  wdata_in, rdata_out, osc_control_code_out, m_coarse, m_fine, m_cfg, f;
  logic [1:0]  coarse_trim_out;
  logic [2:0]  crystal_drive_ctrl_out;
  int          bad_count, compares, a, n, k, s, v, amp;
  logic [7:0]  cfgs [6] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h08, 8'h80};
  logic [7:0]  probes [3] = '{8'h00, 8'hff, 8'h7f};
  // status mode code follows the package enum order: off, low, med, high, custom, ext
  function automatic logic [2:0] mode_of(input logic [7:0] c);
    if (c[3]) begin
      return 3'd5;
    end
    case (c[2:0])
      3'h0: return 3'd0;
      3'h1: return 3'd1;
      3'h3: return 3'd2;
      3'h7: return 3'd3;
      default: return 3'd4;
    endcase
  endfunction
  osc_trim_spread_ctrl dut_u (.*);
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task close_out;
    $display("compares %0d bad %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task do_reset;
    resetn_in <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    m_coarse = 8'h01;
    m_fine = 8'h8e;
    m_cfg = 8'h00;
  endtask
  task wr(input logic [15:0] ad, input logic [7:0] d, input logic u);
    @(posedge sys_clk_in);
    addr_in <= ad;
    wdata_in <= d;
    write_unlock_in <= u;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    if (u && ad == `ADDR_FAST_OSC_COARSE_TRIM) m_coarse = d;
    if (u && ad == `ADDR_FAST_OSC_FINE_TRIM) m_fine = d;
    if (u && ad == `ADDR_CRYSTAL_OSC_CONFIG) m_cfg = d & `CFG_WRITABLE_MASK;
  endtask
  task rd(input logic [15:0] ad, input logic [7:0] e);
    @(posedge sys_clk_in);
    addr_in <= ad;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 `CHK(rdata_out, e)
  endtask
  task chk_out;
    `CHK({coarse_trim_out, slow32k_osc_enable_out, analog_pad_connect_out,
      crystal_ext_clk_sel_out, crystal_osc_powerdown_out, crystal_drive_ctrl_out},
      {m_coarse[1:0], m_cfg[7], m_cfg[7], m_cfg[3], m_cfg[3:0] == 4'h0,
      m_cfg[3] ? 3'h0 : m_cfg[2:0]})
  endtask
  initial begin
    {soft_reset_in, wr_in, rd_in, write_unlock_in, halt_req_in} = '0;
    addr_in = '0;
    wdata_in = '0;
    n = $urandom(32'hf573);
    do_reset();
    rd(`ADDR_FAST_OSC_COARSE_TRIM, 8'h01);
    rd(`ADDR_FAST_OSC_FINE_TRIM, 8'h00);
    rd(16'ha0ff, 8'h00);
    `CHK(osc_control_code_out, 8'h8e)
    rd(`ADDR_OSC_CONTROL_CODE, 8'h8e);
    wr(`ADDR_FAST_OSC_COARSE_TRIM, 8'h5a, 1'b0);
    rd(`ADDR_FAST_OSC_COARSE_TRIM, 8'h01);
    for (k = 0; k < 7; k++) begin
      wr(`ADDR_CRYSTAL_OSC_CONFIG, k < 6 ? cfgs[k] : 8'($urandom), 1'b1);
      rd(`ADDR_CRYSTAL_OSC_CONFIG, m_cfg);
      rd(`ADDR_OSC_STATUS, {3'h0, mode_of(m_cfg), 2'b01});
      chk_out();
    end
    $display("register test done");
    for (a = 0; a < 4; a++) begin
      n = a + 1;
      amp = 4 << a;
      // fine kept inside the unclipped window except where clamping is tried
      f = a == 3 ? 8'd240 : a == 2 ? 8'd5 : 8'(amp + $urandom_range(256 - 2 * amp));
      wr(`ADDR_FAST_OSC_FINE_TRIM, f, 1'b1);
      wr(`ADDR_FAST_OSC_COARSE_TRIM, {n[3:0], a[1:0], 2'b10}, 1'b1);
      // code lags the offset by one edge, so the first look lands two edges after the write
      repeat (2) @(posedge sys_clk_in);
      for (k = 0; k < 4 * amp * n + 4; k++) begin
        s = (k / n) % (4 * amp);
        v = f + (s <= amp ? s : s <= 3 * amp ? 2 * amp - s : s - 4 * amp);
        #1 `CHK(osc_control_code_out, 8'(v < 0 ? 0 : v > 255 ? 255 : v))
        `CHK(sweep_active_out, 1'b1)
        @(posedge sys_clk_in);
      end
      #1 chk_out();
      wr(`ADDR_FAST_OSC_COARSE_TRIM, {4'h0, a[1:0], 2'b11}, 1'b1);
      repeat (2) @(posedge sys_clk_in);
      #1 `CHK(osc_control_code_out, f)
      `CHK(sweep_active_out, 1'b0)
    end
    $display("sweep test done");
    // pad setup and the crystal start-up wait belong to software outside this block
    wr(`ADDR_CRYSTAL_OSC_CONFIG, 8'h87, 1'b1);
    wr(`ADDR_FAST_OSC_COARSE_TRIM, 8'h13, 1'b1);
    @(posedge sys_clk_in);
    soft_reset_in <= 1'b1;
    @(posedge sys_clk_in);
    soft_reset_in <= 1'b0;
    m_coarse = 8'h01;
    repeat (3) @(posedge sys_clk_in);
    #1 `CHK(osc_control_code_out, 8'h8e)
    `CHK(sweep_active_out, 1'b0)
    rd(`ADDR_FAST_OSC_COARSE_TRIM, 8'h01);
    rd(`ADDR_CRYSTAL_OSC_CONFIG, 8'h87);
    $display("soft reset test done");
    @(posedge sys_clk_in);
    halt_req_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #1 `CHK({internal_fast_osc_en_out, internal_fast_osc_ready_out}, 2'b00)
    @(posedge sys_clk_in);
    halt_req_in <= 1'b0;
    repeat (11) @(posedge sys_clk_in);
    #1 `CHK({internal_fast_osc_en_out, internal_fast_osc_ready_out}, 2'b10)
    @(posedge sys_clk_in);
    #1 `CHK(internal_fast_osc_ready_out, 1'b1)
    @(posedge sys_clk_in);
    do_reset();
    rd(`ADDR_CRYSTAL_OSC_CONFIG, 8'h00);
    rd(`ADDR_FAST_OSC_COARSE_TRIM, 8'h01);
    `CHK(osc_control_code_out, 8'h8e)
    wr(`ADDR_FAST_OSC_COARSE_TRIM, 8'h01, 1'b1);
    for (k = 0; k < 3; k++) begin
      wr(`ADDR_FAST_OSC_FINE_TRIM, probes[k], 1'b1);
      rd(`ADDR_OSC_CONTROL_CODE, probes[k]);
      `CHK(osc_control_code_out, probes[k])
    end
    $display("halt and power-on test done");
    close_out();
  end
  // whole run is under a thousand cycles, so this span only trips on a hang
  initial begin
    #200us;
    bad_count++;
    close_out();
  end
endmodule
